// ===== common/rcc_params.svh
/*
 Constants of the calendar core: bus identity, offsets, fields, timing.
 Assumes inclusion by bare name from design and bench files alike.
*/
`ifndef RCC_PARAMS_SVH
`define RCC_PARAMS_SVH
// Bus identification (arbitrary value)
`define RCC_DEV_ADDR 7'h50
// Register offsets
`define RCC_A_SEC 5'h00
`define RCC_A_MIN 5'h01
`define RCC_A_HR 5'h02
`define RCC_A_DAY 5'h03
`define RCC_A_DATE 5'h04
`define RCC_A_MON 5'h05
`define RCC_A_YR 5'h06
`define RCC_A_AL1 5'h07
`define RCC_A_AL2 5'h0B
`define RCC_A_CTRL 5'h0E
`define RCC_A_STAT 5'h0F
`define RCC_REG_LAST 5'h10
// Control fields
`define RCC_B_A1IE 0
`define RCC_B_A2IE 1
`define RCC_B_INTCN 2
`define RCC_B_RS_LO 3
`define RCC_B_RS_HI 4
// Reset values
`define RCC_RST_CTRL 8'h18
`define RCC_RST_ONE 8'h01
// Timing
`define RCC_OSC_DIV_LAST 15'h7FFF
`define RCC_CLK_MHZ 40
`define RCC_REC_TIME_US 2000
`endif

// ===== common/rcc_pkg.sv
/*
 Shared types of the calendar core: byte, serial engine states, byte kinds.
 Assumes compilation ahead of the interface and the design modules.
*/
package rcc_pkg;
   typedef logic [7:0] rcc_byte_t;
   typedef enum logic [2:0] {
      RCC_IDLE = 3'b000,
      RCC_RX = 3'b001,
      RCC_ACK = 3'b010,
      RCC_TX = 3'b011,
      RCC_RACK = 3'b100
   } rcc_st_t;
   typedef enum logic [1:0] {
      RCC_K_ADDR = 2'b00,
      RCC_K_PTR = 2'b01,
      RCC_K_DATA = 2'b10
   } rcc_kind_t;
endpackage

// ===== common/rcc_bus_if.sv
/*
 Internal register access link between the serial slave and the core.
 Assumes both ends run on the same system clock.
*/
`timescale 1ns/10ps
interface rcc_bus_if;
   logic start_p;
   logic stop_p;
   logic wr_p;
   logic wrap_p;
   logic [4:0] ptr;
   rcc_pkg::rcc_byte_t wdata;
   rcc_pkg::rcc_byte_t rdata;
   modport slave (output start_p, stop_p, wr_p, wrap_p, ptr, wdata,
                  input rdata);
   modport core (input start_p, stop_p, wr_p, wrap_p, ptr, wdata,
                 output rdata);
endinterface

// ===== rtl/rcc_i2c_slave.sv
/*
 Two-wire serial bus target: condition detection, byte shifting,
 acknowledge and the auto-incrementing register pointer.
 Assumes SCL and SDA arrive asynchronously; the bench resolves SDA.
*/
`timescale 1ns/10ps
`include "rcc_params.svh"
module rcc_i2c_slave (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_oe_n_o,
   rcc_bus_if.slave bus
);
   logic scl_s1, scl_s2, scl_q, sda_s1, sda_s2, sda_q;
   logic scl_rise, scl_fall, start_c, stop_c, rw_q, adv_q;
   logic [3:0] cnt_q;
   rcc_pkg::rcc_byte_t sh_q;
   rcc_pkg::rcc_st_t st_q;
   rcc_pkg::rcc_kind_t kind_q;

   // Two-stage synchronisers plus one history stage for edges
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_q <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_s1 <= scl_i;
         scl_s2 <= scl_s1;
         scl_q <= scl_s2;
         sda_s1 <= sda_i;
         sda_s2 <= sda_s1;
         sda_q <= sda_s2;
      end
   end

   // SDA moving while SCL is high marks START or STOP
   assign scl_rise = scl_s2 & ~scl_q;
   assign scl_fall = ~scl_s2 & scl_q;
   assign start_c = scl_s2 & scl_q & sda_q & ~sda_s2;
   assign stop_c = scl_s2 & scl_q & ~sda_q & sda_s2;

   // Protocol engine; only follows the master's clock, never drives SCL
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q <= rcc_pkg::RCC_IDLE;
         kind_q <= rcc_pkg::RCC_K_ADDR;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         rw_q <= 1'b0;
         adv_q <= 1'b0;
         sda_oe_n_o <= 1'b1;
         bus.ptr <= 5'h00;
         bus.wdata <= 8'h00;
         bus.start_p <= 1'b0;
         bus.stop_p <= 1'b0;
         bus.wr_p <= 1'b0;
         bus.wrap_p <= 1'b0;
      end else begin
         bus.start_p <= 1'b0;
         bus.stop_p <= 1'b0;
         bus.wr_p <= 1'b0;
         bus.wrap_p <= 1'b0;
         adv_q <= 1'b0;
         // Pointer moves one cycle after the byte so the core sees the old one
         if (adv_q) begin
            if (bus.ptr == `RCC_REG_LAST) begin
               bus.ptr <= 5'h00;
               bus.wrap_p <= 1'b1;
            end else begin
               bus.ptr <= bus.ptr + 5'h01;
            end
         end
         if (start_c) begin
            st_q <= rcc_pkg::RCC_RX;
            kind_q <= rcc_pkg::RCC_K_ADDR;
            cnt_q <= 4'h0;
            sda_oe_n_o <= 1'b1;
            bus.start_p <= 1'b1;
         end else if (stop_c) begin
            st_q <= rcc_pkg::RCC_IDLE;
            sda_oe_n_o <= 1'b1;
            bus.stop_p <= 1'b1;
         end else begin
            case (st_q)
               rcc_pkg::RCC_RX: begin
                  if (scl_rise) begin
                     sh_q <= {sh_q[6:0], sda_s2};
                     cnt_q <= cnt_q + 4'h1;
                  end else if (scl_fall && cnt_q == 4'h8) begin
                     cnt_q <= 4'h0;
                     sda_oe_n_o <= 1'b0;
                     st_q <= rcc_pkg::RCC_ACK;
                     case (kind_q)
                        rcc_pkg::RCC_K_ADDR: begin
                           rw_q <= sh_q[0];
                           kind_q <= rcc_pkg::RCC_K_PTR;
                           if (sh_q[7:1] != `RCC_DEV_ADDR) begin
                              sda_oe_n_o <= 1'b1; // Not ours: stay quiet
                              st_q <= rcc_pkg::RCC_IDLE;
                           end
                        end
                        rcc_pkg::RCC_K_PTR: begin
                           kind_q <= rcc_pkg::RCC_K_DATA;
                           bus.ptr <= (sh_q > {3'h0, `RCC_REG_LAST}) ?
                              5'h00 : sh_q[4:0];
                        end
                        default: begin
                           bus.wdata <= sh_q;
                           bus.wr_p <= 1'b1;
                           adv_q <= 1'b1;
                        end
                     endcase
                  end
               end
               rcc_pkg::RCC_ACK: begin
                  if (scl_fall) begin
                     sda_oe_n_o <= 1'b1;
                     st_q <= rcc_pkg::RCC_RX;
                     if (rw_q) begin
                        sh_q <= bus.rdata;
                        sda_oe_n_o <= bus.rdata[7];
                        adv_q <= 1'b1;
                        st_q <= rcc_pkg::RCC_TX;
                     end
                  end
               end
               rcc_pkg::RCC_TX: begin
                  if (scl_fall) begin
                     if (cnt_q == 4'h7) begin
                        sda_oe_n_o <= 1'b1;
                        st_q <= rcc_pkg::RCC_RACK;
                     end else begin
                        sh_q <= {sh_q[6:0], 1'b0};
                        sda_oe_n_o <= sh_q[6];
                        cnt_q <= cnt_q + 4'h1;
                     end
                  end
               end
               rcc_pkg::RCC_RACK: begin
                  if (scl_rise && sda_s2) begin
                     st_q <= rcc_pkg::RCC_IDLE; // Master ended the read
                  end else if (scl_fall) begin
                     sh_q <= bus.rdata;
                     sda_oe_n_o <= bus.rdata[7];
                     cnt_q <= 4'h0;
                     adv_q <= 1'b1;
                     st_q <= rcc_pkg::RCC_TX;
                  end
               end
               default: st_q <= rcc_pkg::RCC_IDLE;
            endcase
         end
      end
   end
endmodule // rcc_i2c_slave

// ===== rtl/rcc_top.sv
/*
 Calendar clock core with two alarms, wave/interrupt pin and serial
 register access. Assumes a 40 MHz system clock, a 32.768 kHz reference
 on osc_in_pin_i and a power-fail flag already in the system domain.
*/
`timescale 1ns/10ps
`include "rcc_params.svh"
module rcc_top #(
   parameter int REC_CYCLES = `RCC_REC_TIME_US * `RCC_CLK_MHZ
) (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   input wire logic osc_in_pin_i,
   input wire logic power_fail_i,
   output logic wave_or_irq_out_o,
   output logic wave_or_irq_out_oe_n_o
);
   rcc_bus_if bus ();
   rcc_pkg::rcc_byte_t regs_q [0:16];
   rcc_pkg::rcc_byte_t shadow_q [0:6];
   logic osc_s1, osc_s2, osc_q, osc_rise, tick_q, chk_q, ok_q;
   logic [14:0] div_q;
   logic [16:0] rec_q;
   logic [1:0] match;
   logic sec_end, min_end, hr_end, date_end, mon_end, yr_end;
   logic mode12, irq, sqw;
   rcc_pkg::rcc_byte_t hr_nx;

   rcc_i2c_slave u_slave (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_oe_n_o(sda_oe_n_o),
      .bus(bus)
   );

   // BCD increment of one byte
   function automatic rcc_pkg::rcc_byte_t bcd_inc(
      input rcc_pkg::rcc_byte_t v);
      bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} :
         {v[7:4], v[3:0] + 4'h1};
   endfunction

   // Last date of the month in BCD; years divisible by four are leap
   function automatic rcc_pkg::rcc_byte_t mdays(
      input rcc_pkg::rcc_byte_t mon,
      input rcc_pkg::rcc_byte_t yr);
      logic leap;
      leap = (~yr[4] & (yr[3:0] == 4'h0 | yr[3:0] == 4'h4 |
         yr[3:0] == 4'h8)) | (yr[4] & (yr[3:0] == 4'h2 |
         yr[3:0] == 4'h6));
      case (mon[4:0])
         5'h02: mdays = leap ? 8'h29 : 8'h28;
         5'h04, 5'h06, 5'h09, 5'h11: mdays = 8'h30;
         default: mdays = 8'h31;
      endcase
   endfunction

   // Reference pin is sampled twice before use
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         osc_s1 <= 1'b0;
         osc_s2 <= 1'b0;
         osc_q <= 1'b0;
      end else begin
         osc_s1 <= osc_in_pin_i;
         osc_s2 <= osc_s1;
         osc_q <= osc_s2;
      end
   end
   assign osc_rise = osc_s2 & ~osc_q;

   // Divider to one second; chk_q evaluates alarms after the update
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_q <= 15'h0000;
         tick_q <= 1'b0;
         chk_q <= 1'b0;
      end else begin
         tick_q <= 1'b0;
         chk_q <= tick_q;
         if (osc_rise) begin
            div_q <= div_q + 15'h0001;
            tick_q <= (div_q == `RCC_OSC_DIV_LAST);
         end
      end
   end

   // Recovery timer; reset assumes the supply is already good
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ok_q <= 1'b1;
         rec_q <= 17'h00000;
      end else if (power_fail_i) begin
         ok_q <= 1'b0;
         rec_q <= 17'h00000;
      end else if (!ok_q) begin
         rec_q <= rec_q + 17'h00001;
         if (rec_q == 17'(REC_CYCLES - 1)) begin
            ok_q <= 1'b1;
         end
      end
   end

   // Carry conditions of the chain
   assign mode12 = regs_q[`RCC_A_HR][6];
   assign sec_end = regs_q[`RCC_A_SEC][6:0] == 7'h59;
   assign min_end = regs_q[`RCC_A_MIN][6:0] == 7'h59;
   assign hr_end = mode12 ? (regs_q[`RCC_A_HR][5:0] == 6'h31) :
      (regs_q[`RCC_A_HR][5:0] == 6'h23);
   assign date_end = regs_q[`RCC_A_DATE] ==
      mdays(regs_q[`RCC_A_MON], regs_q[`RCC_A_YR]);
   assign mon_end = regs_q[`RCC_A_MON][4:0] == 5'h12;
   assign yr_end = regs_q[`RCC_A_YR] == 8'h99;

   // Next hour; in 12-hour mode 11 to 12 flips the PM bit
   always_comb begin
      hr_nx = bcd_inc(regs_q[`RCC_A_HR]);
      if (mode12) begin
         if (regs_q[`RCC_A_HR][4:0] == 5'h12) begin
            hr_nx = {regs_q[`RCC_A_HR][7:5], 5'h01};
         end else if (regs_q[`RCC_A_HR][4:0] == 5'h11) begin
            hr_nx = {regs_q[`RCC_A_HR][7:6], ~regs_q[`RCC_A_HR][5],
               5'h12};
         end
      end else if (hr_end) begin
         hr_nx = {regs_q[`RCC_A_HR][7:6], 6'h00};
      end
   end

   // Per-alarm match; fields with the mask bit set are don't-care
   for (genvar g = 0; g < 2; g++) begin : g_alarm
      localparam int B = (g == 0) ? 8 : 11;
      rcc_pkg::rcc_byte_t dd;
      logic sec_ok;
      assign dd = regs_q[B + 2];
      assign sec_ok = (g == 1) || regs_q[7][7] ||
         (regs_q[7][6:0] == regs_q[`RCC_A_SEC][6:0]);
      assign match[g] = sec_ok &&
         (regs_q[B][7] || regs_q[B][6:0] == regs_q[`RCC_A_MIN][6:0]) &&
         (regs_q[B + 1][7] ||
          regs_q[B + 1][6:0] == regs_q[`RCC_A_HR][6:0]) &&
         (dd[7] || (dd[6] ? dd[3:0] == regs_q[`RCC_A_DAY][3:0] :
          dd[5:0] == regs_q[`RCC_A_DATE][5:0]));
   end

   // Time counters, host writes and alarm flags; counting ignores ok_q
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < 17; i++) begin
            regs_q[i] <= 8'h00;
         end
         regs_q[`RCC_A_DAY] <= `RCC_RST_ONE;
         regs_q[`RCC_A_DATE] <= `RCC_RST_ONE;
         regs_q[`RCC_A_MON] <= `RCC_RST_ONE;
         regs_q[`RCC_A_CTRL] <= `RCC_RST_CTRL;
      end else begin
         if (tick_q) begin
            regs_q[`RCC_A_SEC] <= sec_end ? 8'h00 :
               bcd_inc(regs_q[`RCC_A_SEC]);
            if (sec_end) begin
               regs_q[`RCC_A_MIN] <= min_end ? 8'h00 :
                  bcd_inc(regs_q[`RCC_A_MIN]);
            end
            if (sec_end && min_end) begin
               regs_q[`RCC_A_HR] <= hr_nx;
            end
            if (sec_end && min_end && hr_end) begin
               regs_q[`RCC_A_DAY] <= (regs_q[`RCC_A_DAY] == 8'h07) ?
                  `RCC_RST_ONE : bcd_inc(regs_q[`RCC_A_DAY]);
               regs_q[`RCC_A_DATE] <= date_end ? `RCC_RST_ONE :
                  bcd_inc(regs_q[`RCC_A_DATE]);
            end
            if (sec_end && min_end && hr_end && date_end) begin
               regs_q[`RCC_A_MON] <= mon_end ?
                  {regs_q[`RCC_A_MON][7] ^ yr_end, 7'h01} :
                  bcd_inc(regs_q[`RCC_A_MON]);
               if (mon_end) begin
                  regs_q[`RCC_A_YR] <= yr_end ? 8'h00 :
                     bcd_inc(regs_q[`RCC_A_YR]);
               end
            end
         end
         // Host write wins over the tick; blocked during power fail
         if (bus.wr_p && ok_q) begin
            regs_q[bus.ptr] <= bus.wdata;
         end
         // Flags: writing 0 clears, writing 1 keeps, a new match wins
         regs_q[`RCC_A_STAT][1:0] <= regs_q[`RCC_A_STAT][1:0] &
            ((bus.wr_p && ok_q && bus.ptr == `RCC_A_STAT) ?
            bus.wdata[1:0] : 2'b11) |
            {chk_q & match[1] & (regs_q[`RCC_A_SEC][6:0] == 7'h00),
            chk_q & match[0]};
      end
   end

   // Read shadow, refreshed at bus boundaries so reads are coherent
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < 7; i++) begin
            shadow_q[i] <= 8'h00;
         end
      end else if (bus.start_p || bus.stop_p || bus.wrap_p) begin
         for (int i = 0; i < 7; i++) begin
            shadow_q[i] <= regs_q[i];
         end
      end
   end

   // Read data; time comes from the shadow, all ones while blocked
   always_comb begin
      if (!ok_q) begin
         bus.rdata = 8'hFF;
      end else if (bus.ptr < `RCC_A_AL1) begin
         bus.rdata = shadow_q[bus.ptr[2:0]];
      end else begin
         bus.rdata = regs_q[bus.ptr];
      end
   end

   // Output pin source: interrupt when INTCN set, else selected wave
   assign irq = (regs_q[`RCC_A_STAT][0] &
      regs_q[`RCC_A_CTRL][`RCC_B_A1IE]) |
      (regs_q[`RCC_A_STAT][1] & regs_q[`RCC_A_CTRL][`RCC_B_A2IE]);
   always_comb begin
      case (regs_q[`RCC_A_CTRL][`RCC_B_RS_HI:`RCC_B_RS_LO])
         2'b00: sqw = div_q[14];
         2'b01: sqw = div_q[2];
         2'b10: sqw = div_q[1];
         default: sqw = osc_s2;
      endcase
   end

   // Open drain: enable low pulls the line low; a high level releases
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wave_or_irq_out_o <= 1'b0;
         wave_or_irq_out_oe_n_o <= 1'b1;
         sda_o <= 1'b0;
      end else begin
         wave_or_irq_out_o <= 1'b0;
         sda_o <= 1'b0;
         wave_or_irq_out_oe_n_o <= regs_q[`RCC_A_CTRL][`RCC_B_INTCN] ?
            ~irq : sqw;
      end
   end
endmodule // rcc_top

// ===== dv/rcc_assertions.sv
/*
 Pin checker for the calendar core: bus target behaviour and pin drive.
 Assumes SCL low phases of several system clocks, as the bench makes.
*/
`timescale 1ns/10ps
module rcc_chk #(
   parameter int REC_CYCLES = 80000
) (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   input wire logic osc_in_pin_i,
   input wire logic power_fail_i,
   input wire logic wave_or_irq_out_o,
   input wire logic wave_or_irq_out_oe_n_o
);
   logic scl_q;
   logic scl_rise;
   logic [3:0] bit_q;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   assign scl_rise = scl_i && !scl_q;
   // Bus clock one cycle late, for edge finding
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         scl_q <= 1'b1;
      end else begin
         scl_q <= scl_i;
      end
   end
   // Bit slot in the byte; slot 8 is the acknowledge, START restarts
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bit_q <= 4'h0;
      end else if ($fell(sda_i) && scl_i && scl_q) begin
         bit_q <= 4'h0;
      end else if (scl_rise) begin
         bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
      end
   end
   a_sda_low_only: assert property (sda_o == 1'b0)
      else $error("SDA data pin not held low");
   a_wave_low_only: assert property (wave_or_irq_out_o == 1'b0)
      else $error("Wave pin data not held low");
   a_no_start_made: assert property ($fell(sda_oe_n_o) |->
      !scl_i && !$past(scl_i)) else $error("SDA pulled while SCL high");
   a_no_stop_made: assert property ($rose(sda_oe_n_o) |->
      !scl_i && !$past(scl_i)) else $error("SDA freed while SCL high");
   a_reset_pins_off: assert property ($rose(reset_n_i) |->
      sda_oe_n_o && wave_or_irq_out_oe_n_o)
      else $error("Pins driven out of reset");
   a_start_quiet: assert property ($fell(sda_i) && scl_i &&
      $past(scl_i) |-> sda_oe_n_o [*8]) else $error("SDA driven at START");
   a_stop_quiet: assert property ($rose(sda_i) && scl_i &&
      $past(scl_i) |=> sda_oe_n_o [*8]) else $error("SDA driven after STOP");
   a_fail_reads_ones: assert property (power_fail_i && scl_rise &&
      bit_q != 4'h8 |-> sda_oe_n_o) else $error("Data bit low in power fail");
   c_start: cover property ($fell(sda_i) && scl_i && scl_q);
   c_ack: cover property (scl_rise && bit_q == 4'h8 && !sda_oe_n_o);
   c_wave: cover property ($fell(wave_or_irq_out_oe_n_o));
endmodule // rcc_chk

bind rcc_top rcc_chk #(.REC_CYCLES(REC_CYCLES)) i_chk (
   .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .scl_i(scl_i),
   .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
   .osc_in_pin_i(osc_in_pin_i), .power_fail_i(power_fail_i),
   .wave_or_irq_out_o(wave_or_irq_out_o),
   .wave_or_irq_out_oe_n_o(wave_or_irq_out_oe_n_o));

// ===== dv/rcc_i2c_master.sv
/*
 Behavioural two-wire bus master, 200 ns bit period, open drain.
 Assumes the bench resolves SDA with a pull-up; SCL idles high.
*/
`timescale 1ns/10ps
module rcc_i2c_master (
   output logic scl_o,
   output logic sda_rel_o,
   input wire logic sda_i
);
   int slow_ns = 0; // Extra SCL low time for a slow master
   initial begin
      scl_o = 1'b1;
      sda_rel_o = 1'b1;
   end
   // One bit: data set mid-low, sampled late in the high phase
   task automatic bit_io(input logic b, output logic r);
      #(50 + slow_ns) sda_rel_o = b;
      #85 scl_o = 1'b1;
      #60 r = sda_i;
      #5 scl_o = 1'b0;
   endtask
   // START or repeated START; leaves SCL low
   task automatic start();
      #50 sda_rel_o = 1'b1;
      #85 scl_o = 1'b1;
      #60 sda_rel_o = 1'b0;
      #60 scl_o = 1'b0;
   endtask
   // STOP, then bus free time with the wire released
   task automatic stop();
      #50 sda_rel_o = 1'b0;
      #85 scl_o = 1'b1;
      #60 sda_rel_o = 1'b1;
      #100;
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // Last byte is answered with NACK so the target lets go
   task automatic recv(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(last, r);
   endtask
endmodule // rcc_i2c_master

// ===== dv/tb_top.sv
/*
 Self-checking bench: register access, pointer wrap, power fail, wave pin.
 Assumes the master model and the bound pin checker.
*/
`timescale 1ns/10ps
`include "rcc_params.svh"
module tb_top;
   localparam int REC = 400; // Short recovery delay keeps the run brief
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic osc = 1'b0;
   logic power_fail = 1'b0;
   logic scl;
   logic sda_rel;
   logic sda;
   logic sda_o;
   logic sda_oe_n;
   logic wave_o;
   logic wave_oe_n;
   int errors = 0;
   int tests_run = 0;
   logic [7:0] tx_q [$];
   logic [7:0] rx_q [$];
   always #12.5 clk = ~clk;
   always #250 osc = ~osc;
   // Pull-up on SDA: low when either party pulls
   assign sda = sda_rel & (sda_oe_n | sda_o);
   rcc_top #(.REC_CYCLES(REC)) i_dut (
      .clk_sys_i(clk), .reset_n_i(reset_n), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .osc_in_pin_i(osc),
      .power_fail_i(power_fail), .wave_or_irq_out_o(wave_o),
      .wave_or_irq_out_oe_n_o(wave_oe_n));
   rcc_i2c_master i_master (.scl_o(scl), .sda_rel_o(sda_rel), .sda_i(sda));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Address, pointer, and for reads a repeated START in read direction
   task automatic open_xfer(input logic rd, input logic [7:0] ptr);
      logic a;
      i_master.start();
      i_master.send({`RCC_DEV_ADDR, 1'b0}, a);
      check({7'h00, a}, 8'h01);
      i_master.send(ptr, a);
      check({7'h00, a}, 8'h01);
      if (rd) begin
         i_master.start();
         i_master.send({`RCC_DEV_ADDR, 1'b1}, a);
         check({7'h00, a}, 8'h01);
      end
   endtask
   task automatic reg_write(input logic [7:0] ptr);
      logic a;
      open_xfer(1'b0, ptr);
      foreach (tx_q[i]) begin
         i_master.send(tx_q[i], a);
         check({7'h00, a}, 8'h01);
      end
      i_master.stop();
   endtask
   task automatic reg_read(input logic [7:0] ptr, input int n);
      logic [7:0] d;
      rx_q = {};
      open_xfer(1'b1, ptr);
      for (int i = 0; i < n; i++) begin
         i_master.recv(i == n - 1, d);
         rx_q.push_back(d);
      end
      i_master.stop();
   endtask
   // Pin and reference change counts over a span must match the divider
   task automatic wave_check(input int div);
      int cw;
      int co;
      logic pw;
      logic po;
      cw = 0;
      co = 0;
      pw = wave_oe_n;
      po = osc;
      repeat (400) begin
         @(posedge clk);
         #2;
         cw += int'(wave_oe_n !== pw);
         co += int'(osc !== po);
         pw = wave_oe_n;
         po = osc;
      end
      check(8'((cw >= co / div - 1) && (cw <= co / div + 1)), 8'h01);
   endtask
   task automatic t_reset_values();
      logic [7:0] e;
      reg_read(8'h00, 16);
      for (int i = 0; i < 16; i++) begin
         e = (i == 14) ? `RCC_RST_CTRL : (i inside {3, 4, 5}) ? 8'h01 : 8'h00;
         check(rx_q[i], e);
      end
   endtask
   // Four bytes in one transfer land in four neighbouring registers
   task automatic t_auto_inc();
      tx_q = {8'h15, 8'h30, 8'h12, 8'h05};
      reg_write(8'h07);
      reg_read(8'h07, 4);
      foreach (tx_q[i]) begin
         check(rx_q[i], tx_q[i]);
      end
   endtask
   // Slow master writes across the end of the map into seconds
   task automatic t_wrap();
      i_master.slow_ns = 300;
      tx_q = {8'h5A, 8'h07};
      reg_write(8'h10);
      i_master.slow_ns = 0;
      reg_read(8'h10, 2);
      check(rx_q[0], 8'h5A);
      check(rx_q[1], 8'h07);
   endtask
   task automatic t_bad_addr();
      logic a;
      i_master.start();
      i_master.send({(`RCC_DEV_ADDR ^ 7'h01), 1'b0}, a);
      check({7'h00, a}, 8'h00);
      i_master.stop();
   endtask
   // Blocked access, counting on, and access back only after recovery
   task automatic t_power();
      tx_q = {8'h08}; // Divided wave shows the divider keeps counting
      reg_write({3'b000, `RCC_A_CTRL});
      @(posedge clk);
      #2 power_fail = 1'b1;
      tx_q = {8'h66};
      reg_write(8'h07);
      reg_read(8'h07, 1);
      check(rx_q[0], 8'hFF);
      wave_check(8);
      @(posedge clk);
      #2 power_fail = 1'b0;
      reg_write(8'h07);
      repeat (REC) @(posedge clk);
      #2; // Bus events stay off the sampling edge
      reg_read(8'h07, 1);
      check(rx_q[0], 8'h15);
      tx_q = {8'h77};
      reg_write(8'h07);
      reg_read(8'h07, 1);
      check(rx_q[0], 8'h77);
   endtask
   // Every wave rate, then interrupt mode with no source leaves pin off
   task automatic t_wave();
      int divs [4] = '{32768, 8, 4, 1};
      for (int k = 0; k < 4; k++) begin
         tx_q = {{3'b000, 2'(k), 3'b000}};
         reg_write({3'b000, `RCC_A_CTRL});
         wave_check(divs[k]);
      end
      tx_q = {8'h04};
      reg_write({3'b000, `RCC_A_CTRL});
      wave_check(32768);
      check({7'h00, wave_oe_n}, 8'h01);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      #2 reset_n = 1'b1;
      repeat (3) @(posedge clk);
      #2; // Bus events stay off the sampling edge
      t_reset_values();
      t_auto_inc();
      t_wrap();
      t_bad_addr();
      t_power();
      t_wave();
      finish_test();
   end
   // Watchdog: the whole sequence needs well under this span
   initial begin
      #2000000;
      errors++;
      finish_test();
   end
endmodule // tb_top
